// file: design/iscc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Set port ones raise enable, begin, halt, ack
// - Clear port ones drop enable, begin, interrupt flag, ack
// - Without ack enable, never answer as slave
// - Match own address with write bit only; general call if enabled
// - After START report 0x08, send address
// - After repeated START report 0x10, send address
// - Direction bit picks transmit or receive states
// - Write address acked 0x18, refused 0x20
// - Data sent and acked reports 0x28
// - Data sent and refused reports 0x30
// - Lost arbitration: release, 0x38, retry later
// - Read address acked 0x40, refused 0x48
// - Received byte acked 0x50; ack flag decides
// - Received byte refused 0x58, byte kept
// - Own write address acked reports 0x60
// - Lost arbitration then own write: 0x68
// - General call acked reports 0x70
// - Lost arbitration then general call: 0x78
// - Slave data acked 0x80, after general call 0x90; ack flag decides
// - Halt on bus error: unaddressed, bus released
// - Status code names the service state
// - Misplaced START/STOP: release, flag, 0x00
// - Halt with begin pending forces bus access
module iscc_ctrl
  import iscc_pkg::*;
(
  input  wire logic       clk_in,         // Core clock
  input  wire logic       nrst_in,        // Sync reset, active low
  input  wire logic       link_clk_in,    // Bus engine clock
  input  wire logic [7:0] ctrl_set_in,    // Control set port
  input  wire logic       set_we_in,      // Set port strobe
  input  wire logic [7:0] ctrl_clr_in,    // Control clear port
  input  wire logic       clr_we_in,      // Clear port strobe
  input  wire logic [7:0] shift_byte_in,  // Shift byte write data
  input  wire logic       shift_we_in,    // Shift byte strobe
  input  wire logic [6:0] own_addr_in,    // Own slave address
  input  wire logic       gc_enable_in,   // General call enable
  input  wire logic       scl_in,         // Clock line level
  input  wire logic       sda_in,         // Data line level
  output logic            scl_out,        // Clock line drive level
  output logic            scl_oe_out,     // Clock line pull low
  output logic            sda_out,        // Data line drive level
  output logic            sda_oe_out,     // Data line pull low
  output logic [7:0]      status_out,     // Status code
  output logic [7:0]      shift_byte_out, // Shift byte read data
  output logic [7:0]      ctrl_out        // Control flags
);

  // ----------------------------------------------------------------
  // Crossings
  // ----------------------------------------------------------------
  iscc_sw_t   sw_q;
  iscc_sw_t   sw_d;
  iscc_lk_t   lk_q;
  iscc_lk_t   lk_d;
  iscc_go_t   go_w;
  logic       lrst_n;
  logic       go_p;
  logic       ev_p;
  logic       sd_p;
  logic [13:0] syn;
  logic       scl_s;
  logic       sda_s;
  logic       en_s;
  logic       sta_s;
  logic       sto_s;
  logic       aa_s;
  logic       gc_s;
  logic [6:0] own_s;

  // Reset release reaches the bus engine two link edges late
  iscc_sync #(.W(1)) u_rst (
    .clk_in  (link_clk_in),
    .nrst_in (1'b1),
    .d_in    (nrst_in),
    .q_out   (lrst_n)
  );

  // Own address is quasi-static: change it only while disabled
  iscc_sync #(.W(14)) u_lvl (
    .clk_in  (link_clk_in),
    .nrst_in (lrst_n),
    .d_in    ({scl_in, sda_in, sw_q.en, sw_q.begin_condition_request, sw_q.halt_condition_request, sw_q.aa,
               gc_enable_in, own_addr_in}),
    .q_out   (syn)
  );

  assign {scl_s, sda_s, en_s, sta_s, sto_s, aa_s, gc_s, own_s} = syn;

  iscc_tgl u_go (
    .clk_in    (link_clk_in),
    .nrst_in   (lrst_n),
    .tgl_in    (sw_q.go_t),
    .pulse_out (go_p)
  );

  iscc_tgl u_ev (
    .clk_in    (clk_in),
    .nrst_in   (nrst_in),
    .tgl_in    (lk_q.ev_t),
    .pulse_out (ev_p)
  );

  iscc_tgl u_sd (
    .clk_in    (clk_in),
    .nrst_in   (nrst_in),
    .tgl_in    (lk_q.sd_t),
    .pulse_out (sd_p)
  );

  // Payload held still by the side that toggled until answered
  assign go_w = '{begin_condition_request: sw_q.begin_condition_request, halt_condition_request: sw_q.halt_condition_request, aa: sw_q.aa, tx: sw_q.shb};

  // ----------------------------------------------------------------
  // Software side flags
  // ----------------------------------------------------------------
  always_comb begin
    sw_d = sw_q;
    if (set_we_in) begin
      sw_d.en  = sw_q.en  | ctrl_set_in[CB_EN];
      sw_d.begin_condition_request = sw_q.begin_condition_request | ctrl_set_in[CB_STA];
      sw_d.halt_condition_request = sw_q.halt_condition_request | ctrl_set_in[CB_STO];
      sw_d.aa  = sw_q.aa  | ctrl_set_in[CB_AA];
    end
    if (clr_we_in) begin
      sw_d.en  = sw_d.en  & ~ctrl_clr_in[CB_EN];
      sw_d.begin_condition_request = sw_d.begin_condition_request & ~ctrl_clr_in[CB_STA];
      sw_d.si  = sw_d.si  & ~ctrl_clr_in[CB_SI];
      sw_d.aa  = sw_d.aa  & ~ctrl_clr_in[CB_AA];
    end
    if (shift_we_in) begin
      sw_d.shb = shift_byte_in;
    end
    // Halt request done by the engine
    if (sd_p) begin
      sw_d.halt_condition_request = 1'b0;
    end
    // A bus event beats a clear in the same cycle
    if (ev_p) begin
      sw_d.si   = 1'b1;
      sw_d.stat = lk_q.ev.code;
      sw_d.shb  = lk_q.ev.rx;
    end
    // Falling flag releases the engine
    if (sw_q.si && !sw_d.si) begin
      sw_d.go_t = ~sw_q.go_t;
      sw_d.stat = SC_IDLE;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      sw_q <= SW_RST;
    end else begin
      sw_q <= sw_d;
    end
  end

  // ----------------------------------------------------------------
  // Bus engine on the link clock
  // ----------------------------------------------------------------
  logic       start_det;
  logic       stop_det;
  logic       rise;
  logic       fall;
  logic       tmo;
  logic       rxd;
  logic       txb;
  logic       hit_own;
  logic       hit_gc;
  logic       raise;
  logic [7:0] code;

  always_comb begin
    lk_d      = lk_q;
    raise     = 1'b0;
    code      = SC_BUS_ERR;
    start_det = scl_s & lk_q.scl_p & lk_q.sda_p & ~sda_s;
    stop_det  = scl_s & lk_q.scl_p & ~lk_q.sda_p & sda_s;
    rise      = scl_s & ~lk_q.scl_p;
    fall      = ~scl_s & lk_q.scl_p;
    tmo       = (lk_q.qc == 10'h000);
    rxd       = lk_q.rd & ~lk_q.adr;
    hit_own   = (lk_q.sh[7:1] == own_s) & ~lk_q.sh[0];
    hit_gc    = (lk_q.sh == 8'h00) & gc_s;
    if (lk_q.bitn == 4'h8) begin
      txb = rxd ? ~lk_q.ackb : 1'b1;
    end else begin
      txb = rxd ? 1'b1 : lk_q.sh[7];
    end
    lk_d.scl_p = scl_s;
    lk_d.sda_p = sda_s;
    lk_d.lvl   = 1'b0;
    if (!tmo) begin
      lk_d.qc = lk_q.qc - 10'h001;
    end
    if (start_det) begin
      lk_d.busy = 1'b1;
    end
    if (stop_det) begin
      lk_d.busy = 1'b0;
    end

    case (lk_q.st)
      // Waiting for a begin request or a foreign START
      L_IDLE: begin
        lk_d.scl_oe = 1'b0;
        lk_d.sda_oe = 1'b0;
        lk_d.mst    = 1'b0;
        lk_d.sel    = 1'b0;
        if (en_s && sta_s && (!lk_q.busy || sto_s)) begin
          // Stale halt after our own STOP must not toggle twice
          if (sto_s && lk_q.busy) begin
            lk_d.busy = 1'b0;
            lk_d.sd_t = ~lk_q.sd_t;
          end
          lk_d.mst = 1'b1;
          lk_d.rep = 1'b0;
          lk_d.st  = L_COND;
          lk_d.ph  = 2'd0;
          lk_d.qc  = QTR;
        end else if (en_s && aa_s && start_det) begin
          lk_d.st   = L_SBIT;
          lk_d.adr  = 1'b1;
          lk_d.bitn = 4'h0;
          lk_d.lost = 1'b0;
        end
      end

      // START or repeated START generation
      L_COND: begin
        case (lk_q.ph)
          2'd0: begin
            lk_d.sda_oe = 1'b0;
            if (tmo) begin
              lk_d.scl_oe = 1'b0;
              lk_d.ph     = 2'd1;
            end
          end
          2'd1: begin
            if (scl_s) begin
              lk_d.ph = 2'd2;
              lk_d.qc = QTR;
            end
          end
          2'd2: begin
            if (tmo) begin
              lk_d.sda_oe = 1'b1;
              lk_d.ph     = 2'd3;
              lk_d.qc     = QTR;
            end
          end
          default: begin
            if (tmo) begin
              lk_d.scl_oe = 1'b1;
              raise       = 1'b1;
              code        = lk_q.rep ? SC_RSTART : SC_START;
            end
          end
        endcase
      end

      // Master byte: eight bits then the acknowledge slot
      L_MBIT: begin
        if (start_det || stop_det) begin
          lk_d.mst    = 1'b0;
          lk_d.scl_oe = 1'b0;
          lk_d.sda_oe = 1'b0;
          raise       = 1'b1;
          code        = SC_BUS_ERR;
        end else begin
          case (lk_q.ph)
            2'd0: begin
              lk_d.sda_oe = ~txb;
              if (tmo) begin
                lk_d.scl_oe = 1'b0;
                lk_d.ph     = 2'd1;
              end
            end
            2'd1: begin
              // A slave stretching the clock delays the sample
              if (scl_s) begin
                lk_d.ph = 2'd2;
                lk_d.qc = QTR;
              end
            end
            default: begin
              if (tmo) begin
                lk_d.scl_oe = 1'b1;
                lk_d.ph     = 2'd0;
                lk_d.qc     = QTR;
                if (lk_q.bitn != 4'h8) begin
                  lk_d.sh   = {lk_q.sh[6:0], sda_s};
                  lk_d.bitn = lk_q.bitn + 4'h1;
                  if (txb && !sda_s && !rxd) begin
                    lk_d.mst    = 1'b0;
                    lk_d.scl_oe = 1'b0;
                    lk_d.sda_oe = 1'b0;
                    if (lk_q.adr) begin
                      lk_d.st   = L_SBIT;
                      lk_d.lost = 1'b1;
                    end else begin
                      raise = 1'b1;
                      code  = SC_ARB_LOST;
                    end
                  end
                end else begin
                  raise       = 1'b1;
                  lk_d.sda_oe = 1'b0;
                  lk_d.adr    = 1'b0;
                  if (lk_q.adr && lk_q.rd) begin
                    code = sda_s ? SC_MR_AD_NACK : SC_MR_AD_ACK;
                  end else if (lk_q.adr) begin
                    code = sda_s ? SC_MT_AD_NACK : SC_MT_AD_ACK;
                  end else if (rxd) begin
                    code = lk_q.ackb ? SC_MR_DA_ACK : SC_MR_DA_NACK;
                  end else begin
                    code = sda_s ? SC_MT_DA_NACK : SC_MT_DA_ACK;
                  end
                end
              end
            end
          endcase
        end
      end

      // STOP generation
      L_STOP: begin
        case (lk_q.ph)
          2'd0: begin
            lk_d.sda_oe = 1'b1;
            if (tmo) begin
              lk_d.scl_oe = 1'b0;
              lk_d.ph     = 2'd1;
            end
          end
          2'd1: begin
            if (scl_s) begin
              lk_d.ph = 2'd2;
              lk_d.qc = QTR;
            end
          end
          default: begin
            if (tmo) begin
              lk_d.sda_oe = 1'b0;
              lk_d.mst    = 1'b0;
              lk_d.st     = L_IDLE;
              lk_d.busy   = 1'b0;
              lk_d.qc     = QTR;
              lk_d.sd_t   = ~lk_q.sd_t;
            end
          end
        endcase
      end

      // Slave receive of address or data
      L_SBIT: begin
        if (start_det || stop_det) begin
          lk_d.sda_oe = 1'b0;
          if (lk_q.sel) begin
            lk_d.sel = 1'b0;
            raise    = 1'b1;
            code     = (lk_q.bitn == 4'h0) ? SC_SR_STOP : SC_BUS_ERR;
          end else if (start_det) begin
            lk_d.adr  = 1'b1;
            lk_d.bitn = 4'h0;
          end else begin
            lk_d.st = L_IDLE;
          end
        end else if (rise && lk_q.bitn < 4'h8) begin
          lk_d.sh   = {lk_q.sh[6:0], sda_s};
          lk_d.bitn = lk_q.bitn + 4'h1;
        end else if (fall && lk_q.bitn == 4'h8) begin
          lk_d.bitn = 4'h9;
          if (lk_q.adr) begin
            lk_d.gcall = hit_gc & ~hit_own;
            if ((hit_own || hit_gc) && aa_s) begin
              lk_d.sda_oe = 1'b1;
            end else if (lk_q.lost) begin
              raise = 1'b1;
              code  = SC_ARB_LOST;
            end else begin
              lk_d.st = L_IDLE;
            end
          end else begin
            lk_d.sda_oe = lk_q.ackb;
          end
        end else if (fall && lk_q.bitn == 4'h9) begin
          lk_d.sda_oe = 1'b0;
          lk_d.scl_oe = 1'b1;
          raise       = 1'b1;
          if (lk_q.adr) begin
            lk_d.sel  = 1'b1;
            lk_d.adr  = 1'b0;
            lk_d.lost = 1'b0;
            if (lk_q.gcall) begin
              code = lk_q.lost ? SC_SR_GC_AL : SC_SR_GC;
            end else begin
              code = lk_q.lost ? SC_SR_OWN_AL : SC_SR_OWN;
            end
          end else if (lk_q.ackb) begin
            code = lk_q.gcall ? SC_GC_DA_ACK : SC_SR_DA_ACK;
          end else begin
            // Refused byte ends the selection, clock not held
            lk_d.sel    = 1'b0;
            lk_d.scl_oe = 1'b0;
            code        = lk_q.gcall ? SC_GC_DA_NACK : SC_SR_DA_NACK;
          end
        end
      end

      // Clock held low until software drops the flag, except after bus error, lost arbitration, STOP or refused slave data
      default: begin
        if (go_p) begin
          lk_d.ackb = go_w.aa;
          lk_d.ph   = 2'd0;
          lk_d.qc   = QTR;
          lk_d.bitn = 4'h0;
          if (!lk_q.mst && !lk_q.sel) begin
            lk_d.scl_oe = 1'b0;
            lk_d.sda_oe = 1'b0;
            lk_d.st     = L_IDLE;
            if (go_w.halt_condition_request) begin
              lk_d.sd_t = ~lk_q.sd_t;
            end
          end else if (lk_q.mst && go_w.halt_condition_request) begin
            lk_d.st = L_STOP;
          end else if (lk_q.mst && go_w.begin_condition_request) begin
            lk_d.rep = 1'b1;
            lk_d.st  = L_COND;
          end else if (lk_q.mst) begin
            lk_d.st = L_MBIT;
            lk_d.sh = go_w.tx;
            if (lk_q.ev.code == SC_START || lk_q.ev.code == SC_RSTART) begin
              lk_d.adr = 1'b1;
              lk_d.rd  = go_w.tx[0];
            end
          end else begin
            lk_d.scl_oe = 1'b0;
            lk_d.adr    = 1'b0;
            lk_d.st     = L_SBIT;
          end
        end
      end
    endcase

    // Each event parks the engine and is reported once
    if (raise) begin
      lk_d.ev.code = code;
      lk_d.ev.rx   = lk_d.sh;
      lk_d.ev_t    = ~lk_q.ev_t;
      lk_d.st      = L_WAIT;
    end

    // Disabling drops all bus activity at once
    if (!en_s) begin
      lk_d.st     = L_IDLE;
      lk_d.mst    = 1'b0;
      lk_d.sel    = 1'b0;
      lk_d.scl_oe = 1'b0;
      lk_d.sda_oe = 1'b0;
    end
  end

  always_ff @(posedge link_clk_in) begin
    if (!lrst_n) begin
      lk_q <= LK_RST;
    end else begin
      lk_q <= lk_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign scl_out        = lk_q.lvl;
  assign sda_out        = lk_q.lvl;
  assign scl_oe_out     = lk_q.scl_oe;
  assign sda_oe_out     = lk_q.sda_oe;
  assign status_out     = sw_q.stat;
  assign shift_byte_out = sw_q.shb;
  assign ctrl_out       = {1'b0, sw_q.en, sw_q.begin_condition_request, sw_q.halt_condition_request, sw_q.si, sw_q.aa, 2'b00};

endmodule : iscc_ctrl

`default_nettype wire

// file: design/iscc_pkg.sv
package iscc_pkg;

  // ----------------------------------------------------------------
  // Control flag positions on the set, clear and flag ports
  // ----------------------------------------------------------------
  localparam int unsigned CB_EN  = 6;
  localparam int unsigned CB_STA = 5;
  localparam int unsigned CB_STO = 4;
  localparam int unsigned CB_SI  = 3;
  localparam int unsigned CB_AA  = 2;

  // ----------------------------------------------------------------
  // Status codes
  // ----------------------------------------------------------------
  localparam logic [7:0] SC_BUS_ERR    = 8'h00;
  localparam logic [7:0] SC_START      = 8'h08;
  localparam logic [7:0] SC_RSTART     = 8'h10;
  localparam logic [7:0] SC_MT_AD_ACK  = 8'h18;
  localparam logic [7:0] SC_MT_AD_NACK = 8'h20;
  localparam logic [7:0] SC_MT_DA_ACK  = 8'h28;
  localparam logic [7:0] SC_MT_DA_NACK = 8'h30;
  localparam logic [7:0] SC_ARB_LOST   = 8'h38;
  localparam logic [7:0] SC_MR_AD_ACK  = 8'h40;
  localparam logic [7:0] SC_MR_AD_NACK = 8'h48;
  localparam logic [7:0] SC_MR_DA_ACK  = 8'h50;
  localparam logic [7:0] SC_MR_DA_NACK = 8'h58;
  localparam logic [7:0] SC_SR_OWN     = 8'h60;
  localparam logic [7:0] SC_SR_OWN_AL  = 8'h68;
  localparam logic [7:0] SC_SR_GC      = 8'h70;
  localparam logic [7:0] SC_SR_GC_AL   = 8'h78;
  localparam logic [7:0] SC_SR_DA_ACK  = 8'h80;
  localparam logic [7:0] SC_SR_DA_NACK = 8'h88;
  localparam logic [7:0] SC_GC_DA_ACK  = 8'h90;
  localparam logic [7:0] SC_GC_DA_NACK = 8'h98;
  localparam logic [7:0] SC_SR_STOP    = 8'ha0;
  localparam logic [7:0] SC_IDLE       = 8'hf8;

  // ----------------------------------------------------------------
  // Bus timing on the link clock
  // ----------------------------------------------------------------
  localparam int unsigned LINK_PERIOD_PS = 6000;
  localparam int unsigned QTR_NS         = 2500;
  localparam int unsigned QTR_CYC        = (QTR_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
  localparam logic [9:0]  QTR            = 10'(QTR_CYC);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    L_IDLE = 3'b000,
    L_COND = 3'b001,
    L_MBIT = 3'b010,
    L_STOP = 3'b011,
    L_SBIT = 3'b100,
    L_WAIT = 3'b101
  } iscc_lst_t;

  typedef struct packed {
    logic [7:0] code;
    logic [7:0] rx;
  } iscc_ev_t;

  typedef struct packed {
    logic       begin_condition_request;
    logic       halt_condition_request;
    logic       aa;
    logic [7:0] tx;
  } iscc_go_t;

  typedef struct packed {
    logic       en;
    logic       begin_condition_request;
    logic       halt_condition_request;
    logic       si;
    logic       aa;
    logic [7:0] stat;
    logic [7:0] shb;
    logic       go_t;
  } iscc_sw_t;

  typedef struct packed {
    iscc_lst_t  st;
    logic       mst;
    logic       rd;
    logic       adr;
    logic       rep;
    logic       busy;
    logic       lost;
    logic       gcall;
    logic       sel;
    logic       ackb;
    logic       scl_oe;
    logic       sda_oe;
    logic       scl_p;
    logic       sda_p;
    logic       ev_t;
    logic       sd_t;
    logic       lvl;
    logic [3:0] bitn;
    logic [1:0] ph;
    logic [9:0] qc;
    logic [7:0] sh;
    iscc_ev_t   ev;
  } iscc_lk_t;

  localparam iscc_sw_t SW_RST = '{stat: SC_IDLE, default: '0};
  localparam iscc_lk_t LK_RST = '{st: L_IDLE, scl_p: 1'b1, sda_p: 1'b1, ev: '0,
                                  default: '0};

endpackage : iscc_pkg

// file: design/iscc_sync.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// Two-flop level synchroniser
// ------------------------------------------------------------------
module iscc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_in,   // Destination clock
  input  wire logic         nrst_in,  // Sync reset, active low
  input  wire logic [W-1:0] d_in,     // Foreign-domain levels
  output logic      [W-1:0] q_out     // Synchronised levels
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } iscc_syn_t;

  iscc_syn_t q;
  iscc_syn_t d;

  // First stage feeds only the second one
  always_comb begin
    d    = q;
    d.s1 = d_in;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign q_out = q.s2;
endmodule : iscc_sync

`default_nettype wire

// file: design/iscc_tgl.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// Toggle-to-pulse event crossing
// ------------------------------------------------------------------
module iscc_tgl (
  input  wire logic clk_in,    // Destination clock
  input  wire logic nrst_in,   // Sync reset, active low
  input  wire logic tgl_in,    // Toggle from the other domain
  output logic      pulse_out  // One cycle per toggle
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } iscc_tg_t;

  iscc_tg_t q;
  iscc_tg_t d;

  // Edge seen only between the second and third stage
  always_comb begin
    d    = q;
    d.s1 = tgl_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pulse_out = q.s2 ^ q.s3;
endmodule : iscc_tgl

`default_nettype wire

// file: tb/iscc_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Control and status checks
// ----
module iscc_ctrl_checker (
  input wire logic       clk_in,         // Core clock
  input wire logic       nrst_in,        // Reset
  input wire logic       set_we_in,      // Set strobe
  input wire logic [7:0] ctrl_set_in,    // Set pattern
  input wire logic       clr_we_in,      // Clear strobe
  input wire logic [7:0] ctrl_clr_in,    // Clear pattern
  input wire logic       shift_we_in,    // Shift strobe
  input wire logic [7:0] shift_byte_in,  // Shift data
  input wire logic       scl_out,        // Clock level
  input wire logic       sda_out,        // Data level
  input wire logic [7:0] status_out,     // Status
  input wire logic [7:0] shift_byte_out, // Shift byte
  input wire logic [7:0] ctrl_out        // Flags
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // Flag writes land one edge later; clear wins a tie
  en_set_a: assert property (set_we_in && ctrl_set_in[6] && !clr_we_in |=> ctrl_out[6])
    else $error("enable not set");
  ack_set_a: assert property (set_we_in && ctrl_set_in[2] && !clr_we_in |=> ctrl_out[2])
    else $error("ack enable not set");
  ack_clr_a: assert property (clr_we_in && ctrl_clr_in[2] |=> !ctrl_out[2])
    else $error("ack enable not cleared");
  flag_clr_a: assert property (clr_we_in && ctrl_clr_in[3] && ctrl_out[3] |=> !ctrl_out[3])
    else $error("flag not cleared");
  // Code only means something while the flag is up
  idle_code_a: assert property (!ctrl_out[3] |-> status_out == 8'hf8)
    else $error("idle code wrong");
  code_legal_a: assert property (ctrl_out[3] |-> status_out[2:0] == 3'h0 && status_out <= 8'ha0)
    else $error("illegal code");
  code_stable_a: assert property (ctrl_out[3] && $past(ctrl_out[3]) |-> $stable(status_out))
    else $error("code moved");
  shift_hold_a: assert property (shift_we_in && ctrl_out[3] |=> shift_byte_out == $past(shift_byte_in))
    else $error("shift byte not loaded");
  spare_zero_a: assert property (ctrl_out[7] == 1'b0 && ctrl_out[1:0] == 2'h0)
    else $error("spare flag set");
  // Lines are only ever pulled low, never driven high
  open_drain_a: assert property (!scl_out && !sda_out)
    else $error("line driven high");
  cover property (ctrl_out[3] && status_out == 8'h18);
  cover property (ctrl_out[3] && status_out == 8'h50);
  cover property (ctrl_out[3] && status_out == 8'h80);
endmodule : iscc_ctrl_checker
bind iscc_ctrl iscc_ctrl_checker chk_u (.*);
`default_nettype wire

// file: tb/iscc_peer.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Remote slave on the bus
// ----
module iscc_peer #(
  parameter logic [6:0] ADDR = 7'h2a, // Address answered
  parameter logic [7:0] DATA = 8'h96  // Read byte, top bit 1 so STOP is never blocked
) (
  input  wire logic scl_in, // Clock line
  input  wire logic sda_in, // Data line
  output var  logic oe_out  // Pulls data low
);
  int         n = 0;
  int         b = 0;
  logic       sel = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] sh = 8'h00;
  initial oe_out = 1'b0;
  // START or STOP restarts framing
  always @(sda_in) if (scl_in === 1'b1) begin
    n = 0;
    b = 0;
    if (sda_in) sel = 1'b0;
  end
  always @(posedge scl_in) begin
    sh = {sh[6:0], sda_in};
    n = n + 1;
  end
  // Ack address and written bytes, drive read bytes
  always @(negedge scl_in) begin
    if (n == 9) begin
      n = 0;
      b = b + 1;
    end
    if (n == 8 && b == 0) begin
      sel = sh[7:1] == ADDR;
      rd = sh[0];
    end
    if (n == 8) oe_out = sel && (b == 0 || !rd);
    else oe_out = sel && rd && b > 0 && !DATA[7-n];
  end
endmodule : iscc_peer
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import iscc_pkg::*;
  logic       clk_in = 1'b0;
  logic       link_clk_in = 1'b0;
  logic       nrst_in = 1'b0;
  logic [7:0] set_v = 8'h00, clr_v = 8'h00, sh_v = 8'h00;
  logic       set_we = 1'b0, clr_we = 1'b0, sh_we = 1'b0;
  logic       tb_scl = 1'b0, tb_sda = 1'b0, ack, gc = 1'b0;
  logic       scl_oe, sda_oe, peer_oe;
  logic [7:0] status, shb, ctrl;
  int         n_fail = 0;
  int         checked = 0;
  wire logic  scl_w = !(scl_oe | tb_scl);
  wire logic  sda_w = !(sda_oe | tb_sda | peer_oe);
  iscc_ctrl dut_u (.clk_in, .nrst_in, .link_clk_in, .ctrl_set_in(set_v), .set_we_in(set_we),
    .ctrl_clr_in(clr_v), .clr_we_in(clr_we), .shift_byte_in(sh_v), .shift_we_in(sh_we),
    .own_addr_in(7'h33), .gc_enable_in(gc), .scl_in(scl_w), .sda_in(sda_w), .scl_out(),
    .scl_oe_out(scl_oe), .sda_out(), .sda_oe_out(sda_oe), .status_out(status),
    .shift_byte_out(shb), .ctrl_out(ctrl));
  iscc_peer peer_u (.scl_in(scl_w), .sda_in(sda_w), .oe_out(peer_oe));
  // Clocks, link offset so edges never line up
  initial forever #5 clk_in = !clk_in;
  initial begin
    #1.7;
    forever #3 link_clk_in = !link_clk_in;
  end
  task automatic chk(input string nm, input logic [7:0] e, g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One-cycle strobes on the control ports
  task automatic wr(input logic [7:0] s, c, d, input logic w);
    @(posedge clk_in) #1;
    set_v = s;
    set_we = |s;
    clr_v = c;
    clr_we = |c;
    sh_v = d;
    sh_we = w;
    @(posedge clk_in) #1;
    set_we = 1'b0;
    clr_we = 1'b0;
    sh_we = 1'b0;
  endtask : wr
  task automatic ev(input logic [7:0] code);
    for (int i = 0; i < 20000 && ctrl[CB_SI] !== 1'b1; i++) @(posedge clk_in) #1;
    chk("status", code, status);
  endtask : ev
  // Remote master bit, honours clock stretching
  task automatic bit_io(input logic b, output logic r);
    tb_sda = !b;
    #1000 tb_scl = 1'b0;
    wait (scl_w === 1'b1);
    #1000 r = sda_w;
    tb_scl = 1'b1;
    #200;
  endtask : bit_io
  task automatic send(input logic [7:0] v, output logic a);
    for (int i = 7; i >= 0; i--) bit_io(v[i], a);
    bit_io(1'b1, a);
  endtask : send
  task automatic report_and_stop();
    if (n_fail == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  initial begin
    #800000;
    n_fail++;
    report_and_stop();
  end
  // Master write, repeated start, read, then refused address
  initial begin
    repeat (20) @(posedge clk_in);
    #1 nrst_in = 1'b1;
    repeat (10) @(posedge clk_in) #1;
    wr(8'h44, 8'h00, 8'h00, 1'b0);
    chk("ctrl", 8'h44, ctrl);
    wr(8'h20, 8'h00, 8'h00, 1'b0);
    ev(SC_START);
    wr(8'h00, 8'h28, {7'h2a, 1'b0}, 1'b1);
    ev(SC_MT_AD_ACK);
    wr(8'h00, 8'h08, 8'h5c, 1'b1);
    ev(SC_MT_DA_ACK);
    wr(8'h20, 8'h08, 8'h00, 1'b0);
    ev(SC_RSTART);
    wr(8'h00, 8'h28, {7'h2a, 1'b1}, 1'b1);
    ev(SC_MR_AD_ACK);
    wr(8'h00, 8'h08, 8'h00, 1'b0);
    ev(SC_MR_DA_ACK);
    chk("byte", 8'h96, shb);
    wr(8'h00, 8'h0c, 8'h00, 1'b0);
    ev(SC_MR_DA_NACK);
    chk("byte", 8'h96, shb);
    wr(8'h14, 8'h08, 8'h00, 1'b0);
    wr(8'h20, 8'h00, 8'h00, 1'b0);
    ev(SC_START);
    wr(8'h00, 8'h28, 8'h22, 1'b1);
    ev(SC_MT_AD_NACK);
    wr(8'h14, 8'h08, 8'h00, 1'b0);
    repeat (3000) @(posedge clk_in) #1;
    chk("ctrl", 8'h44, ctrl);
    // Remote master addresses us and writes two bytes
    tb_sda = 1'b1;
    #1000 tb_scl = 1'b1;
    #200;
    send({7'h33, 1'b0}, ack);
    chk("ack", 8'h00, {7'h0, ack});
    ev(SC_SR_OWN);
    wr(8'h00, 8'h08, 8'h00, 1'b0);
    send(8'hc3, ack);
    ev(SC_SR_DA_ACK);
    chk("byte", 8'hc3, shb);
    wr(8'h00, 8'h0c, 8'h00, 1'b0);
    send(8'h3c, ack);
    chk("ack", 8'h01, {7'h0, ack});
    ev(SC_SR_DA_NACK);
    gc = 1'b1;
    wr(8'h04, 8'h08, 8'h00, 1'b0);
    #1000 tb_scl = 1'b0;
    #1000 tb_sda = 1'b1;
    #1000 tb_scl = 1'b1;
    send(8'h00, ack);
    chk("ack", 8'h00, {7'h0, ack});
    ev(SC_SR_GC);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
